// ---- core/wx_core.sv ----
// executor for word moves, exchanges, stack and 16-bit arithmetic instructions
// Operation
// - store HL at HL+d: L at address, H next; 13 clocks
// - load HL from HL+d: L from address, H from next; 11 clocks
// - SP+unsigned n: low byte at address, high above; store 11, load 9
// - store HL at index+d, L then H; 11 clocks IX, 13 IY
// - paged transfer: address bits 19..16 from A low nibble
// - paged second byte wraps within the 64K page, no carry out
// - move BC/DE to alternate pair: 00 BC', 01 DE', 10 HL'
// - DE/HL exchange uses HL, or HL' under alternate prefix; 2 clocks
// - full exchange swaps BC, DE, HL with alternates, AF kept; 2 clocks
// - top of stack exchange: H with SP+1, L with SP; 15 clocks
// - pop priority byte: one read at SP, SP to SP+1, 7 clocks; push at SP-1, 9
// - pair push: high at SP-1, low at SP-2, SP-2; 10 clocks
// - pair pop: low from SP, high from SP+1, SP+2; 7 clocks
// - SP plus unsigned byte, only carry updated; 4 clocks
// - nonzero-to-one: nonzero becomes 1; S,Z from result, LV and C cleared
// - signed BC*DE, high half to HL, low to BC; flags kept; 12 clocks
// - HL plus pair plus carry; S, Z, V, C updated; 4 clocks
// - index plus pair updates only carry; 4 clocks
// - pair increment/decrement, no flags; 2 clocks
// - logical LV is the OR of the four top result bits
`default_nettype none
module wx_core
  import wx_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  input  wire logic     start,
  input  wire wx_cmd_s  cmd,
  input  wire logic [7:0] mem_rdata,
  output var  wx_mem_s  mem_ff,
  output logic          busy_ff,
  output logic          done_ff,
  output var  wx_regs_s regs_ff
);

  wx_cmd_s     cur_ff;
  logic [3:0]  cnt_ff;
  logic [3:0]  len_ff;
  logic [15:0] base_ff;
  logic [3:0]  page_ff;
  logic [15:0] wword_ff;
  logic [15:0] rword_ff;
  logic        rd_ff;
  logic        wr_ff;
  logic        two_ff;
  logic        take;
  logic        fin;
  logic [3:0]  wb;
  logic [15:0] nxt_base;
  logic [3:0]  nxt_page;
  logic [15:0] nxt_wword;
  logic        nxt_rd;
  logic        nxt_wr;
  logic        nxt_two;
  wx_regs_s    nxt_regs;

  function automatic logic [15:0] f_sx(input logic [7:0] d);
    return {{8{d[7]}}, d};
  endfunction : f_sx

  function automatic logic [15:0] f_pair(input wx_regs_s r, input logic [1:0] s);
    logic [15:0] v;
    v = r.sp;
    if (s == 2'h0)
      v = r.bc;
    else if (s == 2'h1)
      v = r.de;
    else if (s == 2'h2)
      v = r.hl;
    return v;
  endfunction : f_pair

  function automatic wx_regs_s f_set_pair(input wx_regs_s r, input logic [1:0] s, input logic [15:0] v);
    wx_regs_s o;
    o = r;
    case (s)
      2'h0: o.bc = v;
      2'h1: o.de = v;
      2'h2: o.hl = v;
      default: o.sp = v;
    endcase
    return o;
  endfunction : f_set_pair

  function automatic logic [15:0] f_idx(input wx_regs_s r, input logic [1:0] i);
    return (i == IDX_IX) ? r.ix : (i == IDX_IY) ? r.iy : r.hl;
  endfunction : f_idx

  function automatic wx_regs_s f_set_idx(input wx_regs_s r, input logic [1:0] i, input logic [15:0] v);
    wx_regs_s o;
    o = r;
    if (i == IDX_IX)
      o.ix = v;
    else if (i == IDX_IY)
      o.iy = v;
    else
      o.hl = v;
    return o;
  endfunction : f_set_idx

  function automatic logic [7:0] f_flags(input logic [7:0] f, input logic [15:0] r, input logic lv, input logic c);
    logic [7:0] o;
    o = f;
    o[FLG_S] = r[15];
    o[FLG_Z] = (r == 16'h0000);
    o[FLG_LV] = lv;
    o[FLG_C] = c;
    return o;
  endfunction : f_flags

  function automatic logic [19:0] f_addr(input logic [3:0] pg, input logic [15:0] b, input logic hi);
    // second byte stays in the page: the 16-bit sum drops its carry
    return {pg, b + {15'h0000, hi}};
  endfunction : f_addr

  function automatic logic [3:0] f_len(input wx_cmd_s c);
    logic [3:0] n;
    n = CYC_TWO;
    case (c.op)
      OP_ST_HLD: n = CYC_ST_HLD;
      OP_LD_HLD: n = CYC_LD_HLD;
      OP_ST_SPN: n = CYC_ST_SPN;
      OP_LD_SPN: n = CYC_LD_SPN;
      OP_ST_IXD: n = CYC_ST_IXD;
      OP_LD_IXD: n = CYC_LD_IXD;
      OP_ST_IYD: n = CYC_ST_IYD;
      OP_LD_IYD: n = CYC_LD_IYD;
      OP_PG_ST: n = c.use_mn ? CYC_PG_STM : CYC_PG_STR;
      OP_PG_LD: n = c.use_mn ? CYC_PG_LDM : CYC_PG_LDR;
      OP_EX_SP: n = CYC_EX_SP;
      OP_POP_PR: n = CYC_POP_PR;
      OP_PUSH_PR: n = CYC_PUSH_PR;
      OP_PUSH: n = CYC_PUSH;
      OP_POP: n = CYC_POP;
      OP_MUL: n = CYC_MUL;
      OP_LD_ALT, OP_ADD_SP, OP_ADC, OP_ADD_IX: n = CYC_FOUR;
      OP_NZ_TO_ONE, OP_AND, OP_OR: n = (c.idx == IDX_HL) ? CYC_TWO : CYC_FOUR;
      default: n = CYC_TWO;
    endcase
    return n;
  endfunction : f_len

  assign take = start && !busy_ff && (cmd.op != OP_NOP);
  assign fin = busy_ff && (cnt_ff == len_ff - 4'h1);
  // top of stack exchange writes only after both bytes are read back
  assign wb = rd_ff ? MEM_WX : MEM_B0;

  // address and store data worked out as the instruction is taken
  always_comb
  begin
    nxt_base = regs_ff.sp;
    nxt_page = 4'h0;
    nxt_wword = regs_ff.hl;
    nxt_rd = 1'b0;
    nxt_wr = 1'b0;
    nxt_two = 1'b1;
    case (cmd.op)
      OP_ST_HLD, OP_LD_HLD: nxt_base = regs_ff.hl + f_sx(cmd.disp);
      OP_ST_SPN, OP_LD_SPN: nxt_base = regs_ff.sp + {8'h00, cmd.disp};
      OP_ST_IXD, OP_LD_IXD: nxt_base = regs_ff.ix + f_sx(cmd.disp);
      OP_ST_IYD, OP_LD_IYD: nxt_base = regs_ff.iy + f_sx(cmd.disp);
      OP_PG_ST, OP_PG_LD:
      begin
        nxt_base = cmd.use_mn ? cmd.imm : f_idx(regs_ff, cmd.idx);
        nxt_page = regs_ff.af[11:8];
      end
      OP_POP_PR: nxt_two = 1'b0;
      OP_PUSH_PR:
      begin
        nxt_base = regs_ff.sp - 16'h0001;
        nxt_wword = {8'h00, regs_ff.pri};
        nxt_two = 1'b0;
      end
      OP_PUSH:
      begin
        nxt_base = regs_ff.sp - 16'h0002;
        nxt_wword = (cmd.sel == 2'h3) ? regs_ff.af : f_pair(regs_ff, cmd.sel);
      end
      default: nxt_base = regs_ff.sp;
    endcase
    case (cmd.op)
      OP_LD_HLD, OP_LD_SPN, OP_LD_IXD, OP_LD_IYD, OP_PG_LD, OP_POP_PR, OP_POP: nxt_rd = 1'b1;
      OP_ST_HLD, OP_ST_SPN, OP_ST_IXD, OP_ST_IYD, OP_PG_ST, OP_PUSH_PR, OP_PUSH: nxt_wr = 1'b1;
      OP_EX_SP:
      begin
        nxt_rd = 1'b1;
        nxt_wr = 1'b1;
      end
      default: nxt_rd = 1'b0;
    endcase
  end

  // sequencing: one instruction at a time, done pulses as it retires
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      cnt_ff <= 4'h0;
      len_ff <= 4'h0;
      cur_ff <= '0;
    end
    else
    begin
      done_ff <= fin;
      if (take)
      begin
        busy_ff <= 1'b1;
        cnt_ff <= 4'h1;
        len_ff <= f_len(cmd);
        cur_ff <= cmd;
      end
      else if (fin)
      begin
        busy_ff <= 1'b0;
        cur_ff.alt <= 1'b0;
      end
      else if (busy_ff)
        cnt_ff <= cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_ff <= 16'h0000;
      page_ff <= 4'h0;
      wword_ff <= 16'h0000;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      two_ff <= 1'b0;
    end
    else if (take)
    begin
      base_ff <= nxt_base;
      page_ff <= nxt_page;
      wword_ff <= nxt_wword;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      two_ff <= nxt_two;
    end
  end

  // byte bus: low byte always goes first, at the base address, high byte at base+1 within the page
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mem_ff <= '0;
    else
    begin
      mem_ff.we <= 1'b0;
      mem_ff.re <= 1'b0;
      if (busy_ff && rd_ff && (cnt_ff == MEM_B0 || (two_ff && cnt_ff == MEM_B1)))
      begin
        mem_ff.re <= 1'b1;
        mem_ff.addr <= f_addr(page_ff, base_ff, cnt_ff == MEM_B1);
      end
      if (busy_ff && wr_ff && (cnt_ff == wb || (two_ff && cnt_ff == wb + 4'h1)))
      begin
        mem_ff.we <= 1'b1;
        mem_ff.addr <= f_addr(page_ff, base_ff, cnt_ff != wb);
        mem_ff.wdata <= (cnt_ff == wb) ? wword_ff[7:0] : wword_ff[15:8];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rword_ff <= 16'h0000;
    else if (busy_ff && rd_ff && cnt_ff == MEM_C0)
      rword_ff[7:0] <= mem_rdata;
    else if (busy_ff && rd_ff && cnt_ff == MEM_C1)
      rword_ff[15:8] <= mem_rdata;
  end

  // register results, committed on the last clock of the instruction
  always_comb
  begin
    logic [16:0] sum;
    logic [31:0] prod;
    logic [15:0] v;
    logic [15:0] src;
    sum = 17'h00000;
    prod = 32'h00000000;
    v = f_idx(regs_ff, cur_ff.idx);
    src = f_pair(regs_ff, cur_ff.sel);
    nxt_regs = regs_ff;
    case (cur_ff.op)
      OP_LD_HLD, OP_LD_SPN, OP_LD_IXD, OP_LD_IYD, OP_PG_LD, OP_EX_SP: nxt_regs.hl = rword_ff;
      OP_LD_ALT:
      begin
        v = cur_ff.src_de ? regs_ff.de : regs_ff.bc;
        if (cur_ff.sel == 2'h0)
          nxt_regs.bc_a = v;
        else if (cur_ff.sel == 2'h1)
          nxt_regs.de_a = v;
        else if (cur_ff.sel == 2'h2)
          nxt_regs.hl_a = v;
      end
      OP_EX_DEHL:
      begin
        nxt_regs.de = cur_ff.alt ? regs_ff.hl_a : regs_ff.hl;
        if (cur_ff.alt)
          nxt_regs.hl_a = regs_ff.de;
        else
          nxt_regs.hl = regs_ff.de;
      end
      OP_EXX:
      begin
        nxt_regs.bc = regs_ff.bc_a;
        nxt_regs.de = regs_ff.de_a;
        nxt_regs.hl = regs_ff.hl_a;
        nxt_regs.bc_a = regs_ff.bc;
        nxt_regs.de_a = regs_ff.de;
        nxt_regs.hl_a = regs_ff.hl;
      end
      OP_POP_PR:
      begin
        nxt_regs.pri = rword_ff[7:0];
        nxt_regs.sp = regs_ff.sp + 16'h0001;
      end
      OP_PUSH_PR: nxt_regs.sp = regs_ff.sp - 16'h0001;
      OP_PUSH: nxt_regs.sp = regs_ff.sp - 16'h0002;
      OP_POP:
      begin
        if (cur_ff.sel == 2'h3)
          nxt_regs.af = rword_ff;
        else
          nxt_regs = f_set_pair(regs_ff, cur_ff.sel, rword_ff);
        nxt_regs.sp = regs_ff.sp + 16'h0002;
      end
      OP_ADD_SP:
      begin
        sum = {1'b0, regs_ff.sp} + {9'h000, cur_ff.disp};
        nxt_regs.sp = sum[15:0];
        nxt_regs.af[FLG_C] = sum[16];
      end
      OP_NZ_TO_ONE:
      begin
        v = (v != 16'h0000) ? 16'h0001 : 16'h0000;
        nxt_regs = f_set_idx(regs_ff, cur_ff.idx, v);
        nxt_regs.af[7:0] = f_flags(regs_ff.af[7:0], v, 1'b0, 1'b0);
      end
      OP_MUL:
      begin
        prod = $signed(regs_ff.bc) * $signed(regs_ff.de);
        nxt_regs.hl = prod[31:16];
        nxt_regs.bc = prod[15:0];
      end
      OP_ADC:
      begin
        sum = {1'b0, regs_ff.hl} + {1'b0, src} + {16'h0000, regs_ff.af[FLG_C]};
        nxt_regs.hl = sum[15:0];
        nxt_regs.af[7:0] = f_flags(regs_ff.af[7:0], sum[15:0],
                                   (regs_ff.hl[15] == src[15]) && (sum[15] != src[15]), sum[16]);
      end
      OP_ADD_IX:
      begin
        // source 2 selects the same index register, not HL
        src = (cur_ff.sel == 2'h2) ? v : src;
        sum = {1'b0, v} + {1'b0, src};
        nxt_regs = f_set_idx(regs_ff, cur_ff.idx, sum[15:0]);
        nxt_regs.af[FLG_C] = sum[16];
      end
      OP_INC: nxt_regs = f_set_pair(regs_ff, cur_ff.sel, src + 16'h0001);
      OP_DEC: nxt_regs = f_set_pair(regs_ff, cur_ff.sel, src - 16'h0001);
      OP_AND, OP_OR:
      begin
        v = (cur_ff.op == OP_AND) ? (v & regs_ff.de) : (v | regs_ff.de);
        nxt_regs = f_set_idx(regs_ff, cur_ff.idx, v);
        nxt_regs.af[7:0] = f_flags(regs_ff.af[7:0], v, |v[15:12], 1'b0);
      end
      default: nxt_regs = regs_ff;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regs_ff <= '0;
      regs_ff.sp <= SP_RST;
    end
    else if (fin)
      regs_ff <= nxt_regs;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_st_hld_len: assert property (
    take && cmd.op == OP_ST_HLD |-> ##12 !done_ff ##1 done_ff)
    else $error("store via HL+d did not retire in 13 clocks");

  a_ld_hld_len: assert property (
    take && cmd.op == OP_LD_HLD |-> !done_ff [*2] ##9 !done_ff ##1 done_ff)
    else $error("load via HL+d did not retire in 11 clocks");

  a_spn_low_byte: assert property (
    take && cmd.op == OP_ST_SPN |-> ##2 mem_ff.we
      && mem_ff.addr[15:0] == $past(regs_ff.sp, 2) + {8'h00, $past(cmd.disp, 2)}
      && mem_ff.wdata == $past(regs_ff.hl[7:0], 2))
    else $error("SP+n store low byte wrong");

  a_ixd_high_byte: assert property (
    take && cmd.op == OP_ST_IXD |-> ##3 mem_ff.we && mem_ff.wdata == $past(regs_ff.hl[15:8], 3)
      && mem_ff.addr[15:0] == $past(regs_ff.ix, 3) + f_sx($past(cmd.disp, 3)) + 16'h0001)
    else $error("IX+d store high byte wrong");

  a_pg_page_bits: assert property (
    take && cmd.op == OP_PG_LD |-> ##2 mem_ff.re && mem_ff.addr[19:16] == $past(regs_ff.af[11:8], 2))
    else $error("paged address upper bits not from A");

  a_pg_wrap: assert property (
    take && cmd.op == OP_PG_LD && cmd.use_mn && cmd.imm == 16'hffff
      |-> ##3 mem_ff.re && mem_ff.addr == {$past(regs_ff.af[11:8], 3), 16'h0000})
    else $error("paged second byte left its page");

  a_dehl_alt: assert property (
    take && cmd.op == OP_EX_DEHL && cmd.alt |=> done_ff == 1'b0 ##1 done_ff
      && regs_ff.hl_a == $past(regs_ff.de, 2) && regs_ff.hl == $past(regs_ff.hl, 2))
    else $error("DE exchange under prefix missed HL'");

  a_exx_swap: assert property (
    take && cmd.op == OP_EXX |-> ##2 regs_ff.bc == $past(regs_ff.bc_a, 2)
      && regs_ff.hl_a == $past(regs_ff.hl, 2) && regs_ff.af == $past(regs_ff.af, 2))
    else $error("full exchange wrong or AF disturbed");

  a_push_sp: assert property (
    take && cmd.op == OP_PUSH |-> ##10 done_ff && regs_ff.sp == $past(regs_ff.sp, 10) - 16'h0002)
    else $error("pair push SP or length wrong");

  a_mul_result: assert property (
    take && cmd.op == OP_MUL |-> ##12 done_ff && regs_ff.af == $past(regs_ff.af, 12)
      && {regs_ff.hl, regs_ff.bc} == 32'($signed($past(regs_ff.bc, 12)) * $signed($past(regs_ff.de, 12))))
    else $error("multiply result or flags wrong");

endmodule : wx_core
`default_nettype wire

// ---- shared/wx_pkg.sv ----
// package: constants and types for the word move, stack and arithmetic executor
`default_nettype none
package wx_pkg;
  // instruction lengths in clocks
  localparam logic [3:0] CYC_ST_HLD  = 4'hd;
  localparam logic [3:0] CYC_LD_HLD  = 4'hb;
  localparam logic [3:0] CYC_ST_SPN  = 4'hb;
  localparam logic [3:0] CYC_LD_SPN  = 4'h9;
  localparam logic [3:0] CYC_ST_IXD  = 4'hb;
  localparam logic [3:0] CYC_LD_IXD  = 4'h9;
  localparam logic [3:0] CYC_ST_IYD  = 4'hd;
  localparam logic [3:0] CYC_LD_IYD  = 4'hb;
  localparam logic [3:0] CYC_PG_STR  = 4'hc;
  localparam logic [3:0] CYC_PG_STM  = 4'hf;
  localparam logic [3:0] CYC_PG_LDR  = 4'ha;
  localparam logic [3:0] CYC_PG_LDM  = 4'hd;
  localparam logic [3:0] CYC_EX_SP   = 4'hf;
  localparam logic [3:0] CYC_POP_PR  = 4'h7;
  localparam logic [3:0] CYC_PUSH_PR = 4'h9;
  localparam logic [3:0] CYC_PUSH    = 4'ha;
  localparam logic [3:0] CYC_POP     = 4'h7;
  localparam logic [3:0] CYC_MUL     = 4'hc;
  localparam logic [3:0] CYC_FOUR    = 4'h4;
  localparam logic [3:0] CYC_TWO     = 4'h2;
  // memory sequencing: issue cycles and capture cycles (one cycle read latency)
  localparam logic [3:0] MEM_B0 = 4'h1;
  localparam logic [3:0] MEM_B1 = 4'h2;
  localparam logic [3:0] MEM_C0 = 4'h3;
  localparam logic [3:0] MEM_C1 = 4'h4;
  localparam logic [3:0] MEM_WX = 4'h4;
  // flag positions in F and reset values
  localparam int unsigned FLG_S  = 7;
  localparam int unsigned FLG_Z  = 6;
  localparam int unsigned FLG_LV = 2;
  localparam int unsigned FLG_C  = 0;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [1:0] IDX_HL = 2'h0;
  localparam logic [1:0] IDX_IX = 2'h1;
  localparam logic [1:0] IDX_IY = 2'h2;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ST_HLD = 5'h01, OP_LD_HLD = 5'h02, OP_ST_SPN = 5'h03,
    OP_LD_SPN = 5'h04, OP_ST_IXD = 5'h05, OP_LD_IXD = 5'h06, OP_ST_IYD = 5'h07,
    OP_LD_IYD = 5'h08, OP_PG_ST = 5'h09, OP_PG_LD = 5'h0a, OP_LD_ALT = 5'h0b,
    OP_EX_DEHL = 5'h0c, OP_EXX = 5'h0d, OP_EX_SP = 5'h0e, OP_POP_PR = 5'h0f,
    OP_PUSH_PR = 5'h10, OP_PUSH = 5'h11, OP_POP = 5'h12, OP_ADD_SP = 5'h13,
    OP_NZ_TO_ONE = 5'h14, OP_MUL = 5'h15, OP_ADC = 5'h16, OP_ADD_IX = 5'h17,
    OP_INC = 5'h18, OP_DEC = 5'h19, OP_AND = 5'h1a, OP_OR = 5'h1b
  } wx_op_e;

  typedef struct packed {
    wx_op_e      op;
    logic [1:0]  sel;
    logic [1:0]  idx;
    logic        src_de;
    logic        use_mn;
    logic        alt;
    logic [7:0]  disp;
    logic [15:0] imm;
  } wx_cmd_s;

  typedef struct packed {
    logic [15:0] af;
    logic [15:0] bc;
    logic [15:0] de;
    logic [15:0] hl;
    logic [15:0] af_a;
    logic [15:0] bc_a;
    logic [15:0] de_a;
    logic [15:0] hl_a;
    logic [15:0] ix;
    logic [15:0] iy;
    logic [15:0] sp;
    logic [7:0]  pri;
  } wx_regs_s;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } wx_mem_s;
endpackage : wx_pkg
`default_nettype wire

// ---- verification/wx_mem_model.sv ----
// byte-wide memory model on the far side of the executor's bus
`default_nettype none
module wx_mem_model
  import wx_pkg::*;
(
  input  wire logic    core_clk,
  input  wire wx_mem_s mem,
  output var  logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bytes_ff [0:1048575];
  initial mem_rdata = 8'h00;
  // one cycle read latency; outside the data cycle the bus inverts every clock so a capture one cycle late never matches
  always @(posedge core_clk)
  begin
    if (mem.we)
      bytes_ff[mem.addr] <= mem.wdata;
    if (mem.re)
      mem_rdata <= bytes_ff[mem.addr];
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule : wx_mem_model
`default_nettype wire

// ---- verification/cpu_word_move_stack_arith_exec_tb.sv ----
// self-checking bench for the word move, stack and arithmetic executor
`default_nettype none
`define WX_CHK(act, expv) begin total_checks++; if ((act) !== (expv)) begin n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, (act), (expv)); end end
module cpu_word_move_stack_arith_exec_tb
  import wx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        rst_n;
  logic        start;
  wx_cmd_s     cmd;
  wx_cmd_s     c;
  logic [7:0]  mem_rdata;
  wx_mem_s     mem_ff;
  logic        busy_ff;
  logic        done_ff;
  wx_regs_s    regs_ff;
  wx_regs_s    exp_regs;
  logic [15:0] tmp;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;

  wx_core dut
  (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .start     (start),
    .cmd       (cmd),
    .mem_rdata (mem_rdata),
    .mem_ff    (mem_ff),
    .busy_ff   (busy_ff),
    .done_ff   (done_ff),
    .regs_ff   (regs_ff)
  );

  wx_mem_model mdl
  (
    .core_clk  (core_clk),
    .mem       (mem_ff),
    .mem_rdata (mem_rdata)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic summarize();
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // a hang leaves the run here instead of spinning forever
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_errors++;
      summarize();
    end
  end

  // issue one instruction, count clocks to done and compare the whole register view
  task automatic run(input wx_op_e op, input int n);
    int k;
    c.op = op;
    @(posedge core_clk);
    cmd <= c;
    start <= 1'b1;
    @(posedge core_clk);
    // the clock presenting start is the first one; start stays up one more edge, where busy must refuse it
    k = 1;
    do
    begin
      @(posedge core_clk);
      start <= 1'b0;
      #1;
      k++;
      if (done_ff !== 1'b1)
        `WX_CHK(busy_ff, 1'b1)
    end
    while (done_ff !== 1'b1 && k < 40);
    `WX_CHK(k, n)
    `WX_CHK(busy_ff, 1'b0)
    `WX_CHK(regs_ff, exp_regs)
  endtask : run

  task automatic cm(input logic [19:0] a, input logic [7:0] v);
    `WX_CHK(mdl.bytes_ff[a], v)
  endtask : cm

  task automatic put16(input logic [15:0] a, input logic [15:0] v);
    mdl.bytes_ff[{4'h0, a}] = v[7:0];
    mdl.bytes_ff[{4'h0, a + 16'h0001}] = v[15:8];
  endtask : put16

  task automatic pop(input logic [1:0] s, input logic [15:0] v);
    put16(exp_regs.sp, v);
    c.sel = s;
    case (s)
      2'h0: exp_regs.bc = v;
      2'h1: exp_regs.de = v;
      2'h2: exp_regs.hl = v;
      default: exp_regs.af = v;
    endcase
    exp_regs.sp = exp_regs.sp + 16'h0002;
    run(OP_POP, 7);
  endtask : pop

  task automatic t_indexed();
    c.disp = 8'hfe;
    run(OP_ST_HLD, 13);
    cm(20'h01232, 8'h34);
    cm(20'h01233, 8'h12);
    put16(16'h1235, 16'hbeef);
    c.disp = 8'h01;
    exp_regs.hl = 16'hbeef;
    run(OP_LD_HLD, 11);
  endtask : t_indexed

  task automatic t_mul_push();
    exp_regs.hl = 16'hffff;
    exp_regs.bc = 16'hfffa;
    run(OP_MUL, 12);
    c.sel = 2'h0;
    exp_regs.sp = 16'h0006;
    run(OP_PUSH, 10);
    cm(20'h00007, 8'hff);
    cm(20'h00006, 8'hfa);
  endtask : t_mul_push

  // offset 0x80 would go backwards if taken as signed
  task automatic t_stack_rel();
    put16(16'h0086, 16'h4321);
    c.disp = 8'h80;
    exp_regs.hl = 16'h4321;
    run(OP_LD_SPN, 9);
    c.disp = 8'h81;
    run(OP_ST_SPN, 11);
    cm(20'h00087, 8'h21);
    cm(20'h00088, 8'h43);
  endtask : t_stack_rel

  task automatic t_index_regs();
    c.idx = IDX_IY;
    c.sel = 2'h1;
    exp_regs.iy = 16'h0003;
    run(OP_ADD_IX, 4);
    c.idx = IDX_IX;
    c.sel = 2'h0;
    exp_regs.ix = 16'hfffa;
    run(OP_ADD_IX, 4);
    c.sel = 2'h2;
    exp_regs.ix = 16'hfff4;
    exp_regs.af[FLG_C] = 1'b1;
    run(OP_ADD_IX, 4);
    c.disp = 8'hfc;
    run(OP_ST_IXD, 11);
    cm(20'h0fff0, 8'h21);
    cm(20'h0fff1, 8'h43);
    run(OP_LD_IXD, 9);
    c.disp = 8'h7f;
    run(OP_ST_IYD, 13);
    cm(20'h00082, 8'h21);
    cm(20'h00083, 8'h43);
    run(OP_LD_IYD, 11);
  endtask : t_index_regs

  task automatic t_paged();
    mdl.bytes_ff[20'h60000] = 8'h5a;
    c.use_mn = 1'b1;
    c.imm = 16'hffff;
    run(OP_PG_ST, 15);
    cm(20'h5ffff, 8'h21);
    cm(20'h50000, 8'h43);
    cm(20'h60000, 8'h5a);
    run(OP_PG_LD, 13);
    c.use_mn = 1'b0;
    c.idx = IDX_HL;
    mdl.bytes_ff[20'h54321] = 8'h77;
    mdl.bytes_ff[20'h54322] = 8'h66;
    exp_regs.hl = 16'h6677;
    run(OP_PG_LD, 10);
  endtask : t_paged

  task automatic t_alt();
    for (int i = 0; i < 3; i++)
    begin
      c.sel = 2'(i);
      c.src_de = i[0];
      tmp = i[0] ? exp_regs.de : exp_regs.bc;
      case (i)
        0: exp_regs.bc_a = tmp;
        1: exp_regs.de_a = tmp;
        default: exp_regs.hl_a = tmp;
      endcase
      run(OP_LD_ALT, 4);
    end
    c.alt = 1'b1;
    tmp = exp_regs.de;
    exp_regs.de = exp_regs.hl_a;
    exp_regs.hl_a = tmp;
    run(OP_EX_DEHL, 2);
    c.alt = 1'b0;
    tmp = exp_regs.de;
    exp_regs.de = exp_regs.hl;
    exp_regs.hl = tmp;
    run(OP_EX_DEHL, 2);
    exp_regs.de = 16'h0003;
    exp_regs.de_a = 16'h6677;
    exp_regs.hl = 16'h0003;
    exp_regs.hl_a = 16'hfffa;
    run(OP_EXX, 2);
  endtask : t_alt

  task automatic t_stack_swap();
    exp_regs.hl = 16'hfffa;
    run(OP_EX_SP, 15);
    cm(20'h00006, 8'h03);
    cm(20'h00007, 8'h00);
    mdl.bytes_ff[20'h00005] = 8'ha5;
    exp_regs.sp = 16'h0005;
    run(OP_PUSH_PR, 9);
    cm(20'h00005, 8'h00);
    mdl.bytes_ff[20'h00005] = 8'h3c;
    exp_regs.pri = 8'h3c;
    exp_regs.sp = 16'h0006;
    run(OP_POP_PR, 7);
  endtask : t_stack_swap

  task automatic t_arith();
    c.disp = 8'hff;
    exp_regs.sp = 16'h0105;
    exp_regs.af[7:0] = 8'hc4;
    run(OP_ADD_SP, 4);
    c.sel = 2'h2;
    exp_regs.hl = 16'hfff4;
    exp_regs.af[7:0] = 8'h81;
    run(OP_ADC, 4);
    c.sel = 2'h3;
    exp_regs.hl = 16'h00fa;
    exp_regs.af[7:0] = 8'h01;
    run(OP_ADC, 4);
    c.sel = 2'h2;
    exp_regs.hl = 16'h00fb;
    run(OP_INC, 2);
    c.sel = 2'h3;
    exp_regs.sp = 16'h0104;
    run(OP_DEC, 2);
  endtask : t_arith

  task automatic t_logic();
    c.idx = IDX_HL;
    exp_regs.hl = 16'h0003;
    exp_regs.af[7:0] = 8'h00;
    run(OP_AND, 2);
    c.idx = IDX_IX;
    exp_regs.ix = 16'hfff7;
    exp_regs.af[7:0] = 8'h84;
    run(OP_OR, 4);
    c.idx = IDX_HL;
    exp_regs.hl = 16'h0001;
    exp_regs.af[7:0] = 8'h00;
    run(OP_NZ_TO_ONE, 2);
    c.sel = 2'h2;
    exp_regs.hl = 16'h0000;
    run(OP_DEC, 2);
    exp_regs.af[7:0] = 8'h40;
    run(OP_NZ_TO_ONE, 2);
  endtask : t_logic

  initial
  begin
    rst_n = 1'b0;
    start = 1'b0;
    cmd = '0;
    c = '0;
    exp_regs = '0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    pop(2'h0, 16'hfffe);
    pop(2'h1, 16'h0003);
    pop(2'h2, 16'h1234);
    pop(2'h3, 16'h35c4);
    t_indexed();
    t_mul_push();
    t_stack_rel();
    t_index_regs();
    t_paged();
    t_alt();
    t_stack_swap();
    t_arith();
    t_logic();
    summarize();
  end
endmodule : cpu_word_move_stack_arith_exec_tb
`default_nettype wire
